// File: hw/ttfs_pkg.sv
// Purpose: Shared constants for the tandem tray feed sequencer
// Assumes: 100 MHz hclk, AHB-Lite register access, active-high sensors
// Notes: Binary sensor inputs are synchronised and debounced before use; levels and edge word are only synchronised
// Summary of operation
// - Tray presence from tray-set input
// - Tray and right paper start lift
// - Pick-up solenoid follows lift motor
// - Lift stops when lift sensor deactivates
// - Lift sensor reactivation restarts lift
// - Deactivated height sensors encode remaining paper
// - Paper out when stack sensor clears
// - Paper end sensor low means out
// - Side fences closed except during transfer
// - Fence solenoids on until rear fence return sensor
// - Fences close after rear fence push
// - Fences closed: request left tray loading
// - Left paper, right empty: push CCW
// - Return sensor: reverse until home position
// - Left tray locked while rear fence moves
// - Tray exit jam: stop, pulse release
// - Leading edge: registration stopped, relay buckles
// - Then registration and relay restart aligned
// - No sheet at jam check: open plate
// - Guide plate open blocks copying, caution
// - Compare primary and secondary signal strengths
// - Missing secondary signal flags double feed
// - Edge positions shift laser write position
package ttfs_pkg;
  localparam int CLK_MHZ = 100;
  localparam int DEBOUNCE_TIME_US = 1000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLK_MHZ;
  localparam int MOTOR_TIMEOUT_MS = 5000;
  localparam int MOTOR_TIMEOUT_CYCLES = MOTOR_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int RELEASE_PULSE_MS = 200;
  localparam int RELEASE_PULSE_CYCLES = RELEASE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int BUCKLE_TIME_US = 20000;
  localparam logic [31:0] BUCKLE_RESET = 32'(BUCKLE_TIME_US * CLK_MHZ);
  localparam int ALIGN_TIME_US = 10000;
  localparam logic [31:0] ALIGN_RESET = 32'(ALIGN_TIME_US * CLK_MHZ);
  localparam int JAMCHK_TIME_US = 300000;
  localparam logic [31:0] JAMCHK_RESET = 32'(JAMCHK_TIME_US * CLK_MHZ);
  localparam logic [7:0] US_THRESH_RESET = 8'h40;
  localparam logic [11:0] EDGE_NOMINAL_RESET = 12'h800;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CLEAR_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] BUCKLE_OFS = 8'h0c;
  localparam logic [7:0] ALIGN_OFS = 8'h10;
  localparam logic [7:0] JAMCHK_OFS = 8'h14;
  localparam logic [7:0] US_THRESH_OFS = 8'h18;
  localparam logic [7:0] EDGE_NOMINAL_OFS = 8'h1c;
  localparam logic [7:0] LASER_SHIFT_OFS = 8'h20;
  // Control and clear bit positions
  localparam int CTRL_FEED_EN = 0;
  localparam int CTRL_XFER_EN = 1;
  localparam int CLEAR_ERRORS = 0;
  localparam int CLEAR_LOAD_MSG = 1;
  // Sensor vector indices
  localparam int SENSOR_COUNT = 18;
  localparam int S_TRAY = 0;
  localparam int S_RIGHT_PAPER = 1;
  localparam int S_LEFT_PAPER = 2;
  localparam int S_LIFT = 3;
  localparam int S_HEIGHT = 4;
  localparam int S_PAPER_END = 8;
  localparam int S_FENCE_OPEN = 9;
  localparam int S_FENCE_CLOSED = 10;
  localparam int S_REAR_RETURN = 11;
  localparam int S_REAR_HOME = 12;
  localparam int S_LCT_JAM = 13;
  localparam int S_REG = 14;
  localparam int S_GUIDE_POS = 15;
  localparam int S_SHEET_FED = 16;
  localparam int S_SPARE = 17;
  // Remaining paper codes
  localparam logic [2:0] LEVEL_FULL = 3'h0;
  localparam logic [2:0] LEVEL_NEAR_END = 3'h4;
endpackage

// File: hw/ttfs_debounce.sv
// Purpose: Two-flop synchroniser and per-bit debounce filter
// Assumes: Inputs come from mechanical sensors outside the clock domain
// Notes: An output bit changes only after COUNT stable cycles
`timescale 1ns/1ps
`default_nettype none
module ttfs_debounce #(
  parameter int WIDTH = 18,
  parameter int COUNT = 100000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] clean_out
);
  localparam int CW = $clog2(COUNT + 1);
  logic [WIDTH-1:0] sync1_reg;
  logic [WIDTH-1:0] sync2_reg;

  // Metastability guard; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [CW-1:0] cnt_reg;
      logic stable_reg;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_reg <= '0;
          stable_reg <= 1'b0;
        end else if (sync2_reg[i] == stable_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg == CW'(COUNT - 1)) begin
          cnt_reg <= '0;
          stable_reg <= sync2_reg[i];
        end else begin
          cnt_reg <= cnt_reg + CW'(1);
        end
      end
      assign clean_out[i] = stable_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// File: hw/ttfs_sequencer.sv
// Purpose: Tray 1 lift, tandem transfer, registration and jam sequencing
// Assumes: Zero-wait AHB-Lite slave, single word transfers only
// Notes: Long times are parameters so simulation can shorten them
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ttfs_sequencer #(
  parameter int DEBOUNCE = ttfs_pkg::DEBOUNCE_CYCLES,
  parameter int MOTOR_TIMEOUT = ttfs_pkg::MOTOR_TIMEOUT_CYCLES,
  parameter int RELEASE_PULSE = ttfs_pkg::RELEASE_PULSE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tray_set,
  input wire logic right_paper,
  input wire logic left_paper,
  input wire logic lift_sensor,
  input wire logic [3:0] height_sensor,
  input wire logic paper_end,
  input wire logic fence_open,
  input wire logic fence_closed,
  input wire logic rear_return,
  input wire logic rear_home_position,
  input wire logic large_capacity_tray_exit_jam,
  input wire logic reg_sensor,
  input wire logic guide_position,
  input wire logic sheet_fed,
  input wire logic [7:0] primary_level,
  input wire logic [7:0] secondary_level,
  input wire logic [11:0] edge_position,
  output logic lift_motor_on,
  output logic pickup_sol_on,
  output logic fence_sol_on,
  output logic rear_motor_ccw,
  output logic rear_motor_cw,
  output logic left_lock_sol_on,
  output logic guide_release_sol_on,
  output logic guide_plate_sol_on,
  output logic reg_motor_on,
  output logic relay_motor_on,
  output logic feed_stop,
  output logic copy_block,
  output logic caution,
  output logic load_left_msg,
  output logic double_feed_err,
  output logic paper_out,
  output logic [2:0] remaining_level,
  output logic [11:0] laser_shift,
  output logic motor_fault
);
  typedef enum logic [1:0] {LIFT_IDLE = 2'b01, LIFT_UP = 2'b10} ttfs_lift_type;
  typedef enum logic [4:0] {
    XF_IDLE = 5'b00001, XF_OPEN = 5'b00010, XF_PUSH = 5'b00100,
    XF_RETURN = 5'b01000, XF_CLOSE = 5'b10000
  } ttfs_xfer_type;
  typedef enum logic [3:0] {
    RG_IDLE = 4'b0001, RG_BUCKLE = 4'b0010, RG_WAIT = 4'b0100, RG_FEED = 4'b1000
  } ttfs_reg_type;

  logic [ttfs_pkg::SENSOR_COUNT-1:0] raw;
  logic [ttfs_pkg::SENSOR_COUNT-1:0] s;
  logic [ttfs_pkg::SENSOR_COUNT-1:0] s_prev_reg;
  logic [7:0] prim_s1_reg, prim_s2_reg, sec_s1_reg, sec_s2_reg;
  logic [11:0] edge_s1_reg, edge_s2_reg;
  logic [1:0] ctrl_reg;
  logic [31:0] buckle_reg, align_reg, jamchk_reg;
  logic [7:0] us_thresh_reg;
  logic [11:0] edge_nominal_reg;
  logic [7:0] addr_reg;
  logic wr_pend_reg;
  logic clr_err, clr_msg;
  ttfs_lift_type lift_reg;
  ttfs_xfer_type xfer_reg;
  ttfs_reg_type rg_reg;
  logic [31:0] lift_tmr_reg, xfer_tmr_reg, rg_cnt_reg, jam_cnt_reg, pulse_reg;
  logic jam_armed_reg, reg_jam_reg, lct_jam_reg;
  logic feeding, reg_rise, lct_rise, fed_rise, dbl_now;

  // Sensor bundle, all filtered before the sequencers see them
  assign raw = {1'b0, sheet_fed, guide_position, reg_sensor, large_capacity_tray_exit_jam,
                rear_home_position, rear_return, fence_closed, fence_open, paper_end,
                height_sensor, lift_sensor, left_paper, right_paper, tray_set};

  ttfs_debounce #(.WIDTH(ttfs_pkg::SENSOR_COUNT), .COUNT(DEBOUNCE)) i_ttfs_debounce (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw_in(raw),
    .clean_out(s)
  );

  // Analogue levels and edge word cross in via two flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prim_s1_reg <= 8'h00;
      prim_s2_reg <= 8'h00;
      sec_s1_reg <= 8'h00;
      sec_s2_reg <= 8'h00;
      edge_s1_reg <= 12'h000;
      edge_s2_reg <= 12'h000;
      s_prev_reg <= '0;
    end else begin
      prim_s1_reg <= primary_level;
      prim_s2_reg <= prim_s1_reg;
      sec_s1_reg <= secondary_level;
      sec_s2_reg <= sec_s1_reg;
      edge_s1_reg <= edge_position;
      edge_s2_reg <= edge_s1_reg;
      s_prev_reg <= s;
    end
  end

  assign reg_rise = s[ttfs_pkg::S_REG] && !s_prev_reg[ttfs_pkg::S_REG];
  assign lct_rise = s[ttfs_pkg::S_LCT_JAM] && !s_prev_reg[ttfs_pkg::S_LCT_JAM];
  assign fed_rise = s[ttfs_pkg::S_SHEET_FED] && !s_prev_reg[ttfs_pkg::S_SHEET_FED];
  assign feeding = ctrl_reg[ttfs_pkg::CTRL_FEED_EN] && !feed_stop;

  // Count of deactivated height sensors
  function automatic logic [2:0] level_code(input logic [3:0] h);
    level_code = 3'(!h[0]) + 3'(!h[1]) + 3'(!h[2]) + 3'(!h[3]);
  endfunction

  // AHB-Lite address phase capture; read data readied for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      addr_reg <= haddr[7:0];
      wr_pend_reg <= hsel && htrans[1] && hwrite && (haddr[31:8] == 24'h00_0000);
      hrdata <= 32'h0000_0000;
      if (hsel && htrans[1] && !hwrite && (haddr[31:8] == 24'h00_0000)) begin
        unique case (haddr[7:0])
          ttfs_pkg::CTRL_OFS: hrdata <= {30'h0, ctrl_reg};
          ttfs_pkg::STATUS_OFS: hrdata <= {16'h0, copy_block, feed_stop, motor_fault,
              double_feed_err, reg_jam_reg, lct_jam_reg, load_left_msg, rear_motor_cw,
              rear_motor_ccw, fence_sol_on, paper_out, remaining_level, lift_motor_on,
              s[ttfs_pkg::S_TRAY]};
          ttfs_pkg::BUCKLE_OFS: hrdata <= buckle_reg;
          ttfs_pkg::ALIGN_OFS: hrdata <= align_reg;
          ttfs_pkg::JAMCHK_OFS: hrdata <= jamchk_reg;
          ttfs_pkg::US_THRESH_OFS: hrdata <= {24'h0, us_thresh_reg};
          ttfs_pkg::EDGE_NOMINAL_OFS: hrdata <= {20'h0, edge_nominal_reg};
          ttfs_pkg::LASER_SHIFT_OFS: hrdata <= {20'h0, laser_shift};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign clr_err = wr_pend_reg && addr_reg == ttfs_pkg::CLEAR_OFS
                   && hwdata[ttfs_pkg::CLEAR_ERRORS];
  assign clr_msg = wr_pend_reg && addr_reg == ttfs_pkg::CLEAR_OFS
                   && hwdata[ttfs_pkg::CLEAR_LOAD_MSG];

  // Data phase writes to configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= 2'h0;
      buckle_reg <= ttfs_pkg::BUCKLE_RESET;
      align_reg <= ttfs_pkg::ALIGN_RESET;
      jamchk_reg <= ttfs_pkg::JAMCHK_RESET;
      us_thresh_reg <= ttfs_pkg::US_THRESH_RESET;
      edge_nominal_reg <= ttfs_pkg::EDGE_NOMINAL_RESET;
    end else if (wr_pend_reg) begin
      unique case (addr_reg)
        ttfs_pkg::CTRL_OFS: ctrl_reg <= hwdata[1:0];
        ttfs_pkg::BUCKLE_OFS: buckle_reg <= hwdata;
        ttfs_pkg::ALIGN_OFS: align_reg <= hwdata;
        ttfs_pkg::JAMCHK_OFS: jamchk_reg <= hwdata;
        ttfs_pkg::US_THRESH_OFS: us_thresh_reg <= hwdata[7:0];
        ttfs_pkg::EDGE_NOMINAL_OFS: edge_nominal_reg <= hwdata[11:0];
        default: ;
      endcase
    end
  end

  // Stack lift sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lift_reg <= LIFT_IDLE;
      lift_tmr_reg <= 32'h0;
      lift_motor_on <= 1'b0;
      pickup_sol_on <= 1'b0;
    end else begin
      unique case (lift_reg)
        LIFT_IDLE: begin
          lift_tmr_reg <= 32'h0;
          // Start on seated tray with paper, stack low
          if (s[ttfs_pkg::S_TRAY] && s[ttfs_pkg::S_RIGHT_PAPER] && s[ttfs_pkg::S_LIFT]
              && !motor_fault) begin
            lift_reg <= LIFT_UP;
            lift_motor_on <= 1'b1;
            pickup_sol_on <= 1'b1;
          end
        end
        LIFT_UP: begin
          lift_tmr_reg <= lift_tmr_reg + 32'h1;
          // Feed height reached, tray pulled, or timeout
          if (!s[ttfs_pkg::S_LIFT] || !s[ttfs_pkg::S_TRAY]
              || lift_tmr_reg == 32'(MOTOR_TIMEOUT - 1)) begin
            lift_reg <= LIFT_IDLE;
            lift_motor_on <= 1'b0;
            pickup_sol_on <= 1'b0;
          end
        end
      endcase
    end
  end

  // Left to right stack transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_reg <= XF_IDLE;
      xfer_tmr_reg <= 32'h0;
      fence_sol_on <= 1'b0;
      rear_motor_ccw <= 1'b0;
      rear_motor_cw <= 1'b0;
      left_lock_sol_on <= 1'b0;
    end else begin
      xfer_tmr_reg <= xfer_tmr_reg + 32'h1;
      // Any stalled step drops all drives
      if (xfer_reg != XF_IDLE && xfer_tmr_reg == 32'(MOTOR_TIMEOUT - 1)) begin
        xfer_reg <= XF_IDLE;
        fence_sol_on <= 1'b0;
        rear_motor_ccw <= 1'b0;
        rear_motor_cw <= 1'b0;
        left_lock_sol_on <= 1'b0;
      end else begin
        unique case (xfer_reg)
          XF_IDLE: begin
            xfer_tmr_reg <= 32'h0;
            // Fences open only for a transfer
            if (ctrl_reg[ttfs_pkg::CTRL_XFER_EN] && s[ttfs_pkg::S_TRAY] && !motor_fault
                && s[ttfs_pkg::S_LEFT_PAPER] && !s[ttfs_pkg::S_RIGHT_PAPER]) begin
              xfer_reg <= XF_OPEN;
              fence_sol_on <= 1'b1;
            end
          end
          XF_OPEN: begin
            if (s[ttfs_pkg::S_FENCE_OPEN]) begin
              xfer_reg <= XF_PUSH;
              xfer_tmr_reg <= 32'h0;
              rear_motor_ccw <= 1'b1;
              left_lock_sol_on <= 1'b1;
            end
          end
          XF_PUSH: begin
            if (s[ttfs_pkg::S_REAR_RETURN]) begin
              xfer_reg <= XF_RETURN;
              xfer_tmr_reg <= 32'h0;
              rear_motor_ccw <= 1'b0;
              rear_motor_cw <= 1'b1;
              fence_sol_on <= 1'b0;
            end
          end
          XF_RETURN: begin
            if (s[ttfs_pkg::S_REAR_HOME]) begin
              xfer_reg <= XF_CLOSE;
              xfer_tmr_reg <= 32'h0;
              rear_motor_cw <= 1'b0;
              left_lock_sol_on <= 1'b0;
            end
          end
          XF_CLOSE: begin
            if (s[ttfs_pkg::S_FENCE_CLOSED]) begin
              xfer_reg <= XF_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Operator message, fault and paper level flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_left_msg <= 1'b0;
      motor_fault <= 1'b0;
      paper_out <= 1'b0;
      remaining_level <= ttfs_pkg::LEVEL_FULL;
    end else begin
      if (xfer_reg == XF_CLOSE && s[ttfs_pkg::S_FENCE_CLOSED]) begin
        load_left_msg <= 1'b1;
      end else if (clr_msg) begin
        load_left_msg <= 1'b0;
      end
      // Sticky fault on any motor timeout
      if ((lift_reg == LIFT_UP && lift_tmr_reg == 32'(MOTOR_TIMEOUT - 1))
          || (xfer_reg != XF_IDLE && xfer_tmr_reg == 32'(MOTOR_TIMEOUT - 1))) begin
        motor_fault <= 1'b1;
      end else if (clr_err) begin
        motor_fault <= 1'b0;
      end
      paper_out <= s[ttfs_pkg::S_TRAY] && !s[ttfs_pkg::S_PAPER_END];
      remaining_level <= level_code(s[ttfs_pkg::S_HEIGHT +: 4]);
    end
  end

  // Registration buckle and release timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rg_reg <= RG_IDLE;
      rg_cnt_reg <= 32'h0;
      reg_motor_on <= 1'b0;
      relay_motor_on <= 1'b0;
    end else if (!feeding) begin
      rg_reg <= RG_IDLE;
      reg_motor_on <= 1'b0;
      relay_motor_on <= 1'b0;
    end else begin
      unique case (rg_reg)
        RG_IDLE: begin
          relay_motor_on <= 1'b1;
          reg_motor_on <= 1'b0;
          rg_cnt_reg <= 32'h0;
          if (reg_rise) begin
            rg_reg <= RG_BUCKLE;
          end
        end
        RG_BUCKLE: begin
          rg_cnt_reg <= rg_cnt_reg + 32'h1;
          if (rg_cnt_reg >= buckle_reg) begin
            rg_reg <= RG_WAIT;
            rg_cnt_reg <= 32'h0;
            relay_motor_on <= 1'b0;
          end
        end
        RG_WAIT: begin
          rg_cnt_reg <= rg_cnt_reg + 32'h1;
          if (rg_cnt_reg >= align_reg) begin
            rg_reg <= RG_FEED;
            reg_motor_on <= 1'b1;
            relay_motor_on <= 1'b1;
          end
        end
        RG_FEED: begin
          if (!s[ttfs_pkg::S_REG]) begin
            rg_reg <= RG_IDLE;
          end
        end
      endcase
    end
  end

  // Secondary signal missing while a sheet crosses the sensor pair
  assign dbl_now = rg_reg == RG_FEED && s[ttfs_pkg::S_REG]
                   && prim_s2_reg > us_thresh_reg && sec_s2_reg <= us_thresh_reg;

  // Jam detection, plate control and feed stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jam_armed_reg <= 1'b0;
      jam_cnt_reg <= 32'h0;
      reg_jam_reg <= 1'b0;
      lct_jam_reg <= 1'b0;
      pulse_reg <= 32'h0;
      guide_release_sol_on <= 1'b0;
      guide_plate_sol_on <= 1'b0;
      double_feed_err <= 1'b0;
      feed_stop <= 1'b0;
      copy_block <= 1'b0;
      caution <= 1'b0;
    end else begin
      if (fed_rise) begin
        jam_armed_reg <= 1'b1;
        jam_cnt_reg <= 32'h0;
      end else if (reg_rise) begin
        jam_armed_reg <= 1'b0;
      end else if (jam_armed_reg) begin
        jam_cnt_reg <= jam_cnt_reg + 32'h1;
        if (jam_cnt_reg >= jamchk_reg) begin
          jam_armed_reg <= 1'b0;
        end
      end
      if (jam_armed_reg && !reg_rise && jam_cnt_reg >= jamchk_reg) begin
        reg_jam_reg <= 1'b1;
      end else if (clr_err) begin
        reg_jam_reg <= 1'b0;
      end
      guide_plate_sol_on <= reg_jam_reg;
      // Exit jam pulses the release solenoid
      if (lct_rise) begin
        lct_jam_reg <= 1'b1;
        pulse_reg <= 32'(RELEASE_PULSE);
      end else begin
        if (clr_err) begin
          lct_jam_reg <= 1'b0;
        end
        if (pulse_reg != 32'h0) begin
          pulse_reg <= pulse_reg - 32'h1;
        end
      end
      guide_release_sol_on <= pulse_reg != 32'h0;
      if (dbl_now) begin
        double_feed_err <= 1'b1;
      end else if (clr_err) begin
        double_feed_err <= 1'b0;
      end
      // Any jam or double feed halts feeding
      if (lct_rise || dbl_now || (jam_armed_reg && jam_cnt_reg >= jamchk_reg)) begin
        feed_stop <= 1'b1;
      end else if (clr_err) begin
        feed_stop <= 1'b0;
      end
      copy_block <= s[ttfs_pkg::S_GUIDE_POS];
      caution <= s[ttfs_pkg::S_GUIDE_POS];
    end
  end

  // Side shift captured at each leading edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      laser_shift <= 12'h000;
    end else if (reg_rise) begin
      laser_shift <= edge_s2_reg - edge_nominal_reg;
    end
  end
endmodule
`default_nettype wire

// File: bench/ttfs_asserts.sv
// Purpose: Port checks for the feed sequencer
// Assumes: One clock, async reset
// Notes: Bound into every sequencer
`timescale 1ns/1ps
`default_nettype none
module ttfs_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic lift_motor_on,
  input wire logic pickup_sol_on,
  input wire logic rear_motor_ccw,
  input wire logic rear_motor_cw,
  input wire logic left_lock_sol_on,
  input wire logic guide_release_sol_on,
  input wire logic guide_plate_sol_on,
  input wire logic feed_stop,
  input wire logic copy_block,
  input wire logic caution,
  input wire logic [2:0] remaining_level
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Jam actions must stop feed within a cycle
  sequence s_stop; ##[0:1] feed_stop; endsequence
  property p_pick; lift_motor_on == pickup_sol_on; endproperty
  a_pick: assert property (p_pick) else $error("pickup not with lift");
  property p_dir; !(rear_motor_ccw && rear_motor_cw); endproperty
  a_dir: assert property (p_dir) else $error("rear motor both ways");
  property p_lock; rear_motor_ccw || rear_motor_cw |-> left_lock_sol_on; endproperty
  a_lock: assert property (p_lock) else $error("left tray unlocked");
  property p_rel; $rose(guide_release_sol_on) |-> guide_release_sol_on [*8]; endproperty
  a_rel: assert property (p_rel) else $error("release pulse short");
  property p_jam; $rose(guide_release_sol_on) |-> s_stop; endproperty
  a_jam: assert property (p_jam) else $error("exit jam no stop");
  property p_plate; $rose(guide_plate_sol_on) |-> s_stop; endproperty
  a_plate: assert property (p_plate) else $error("plate open no stop");
  property p_warn; copy_block == caution; endproperty
  a_warn: assert property (p_warn) else $error("block without caution");
  property p_lvl; remaining_level <= 3'h4; endproperty
  a_lvl: assert property (p_lvl) else $error("level out of range");
endmodule
bind ttfs_sequencer ttfs_asserts i_ttfs_asserts (.*);
`default_nettype wire

// File: bench/ttfs_plant.sv
// Purpose: Sensor model around the feed sequencer
// Assumes: Motors move one step a cycle
// Notes: No reset; stack starts low, rear fence at home
`timescale 1ns/1ps
`default_nettype none
module ttfs_plant (
  input wire logic hclk,
  input wire logic lift_motor_on,
  input wire logic fence_sol_on,
  input wire logic rear_motor_ccw,
  input wire logic rear_motor_cw,
  input wire logic feed,
  input wire logic stall,
  output logic lift_sensor,
  output logic fence_open,
  output logic fence_closed,
  output logic rear_return,
  output logic rear_home_position
);
  logic [3:0] stack = 4'h0;
  logic [3:0] pos = 4'h0;
  // stack height, rear travel, fences lag a cycle
  always @(posedge hclk) begin
    if (feed) stack <= 4'h0;
    else if (lift_motor_on && !stall && stack < 4'h8) stack <= stack + 4'h1;
    if (rear_motor_ccw && pos < 4'h8) pos <= pos + 4'h1;
    else if (rear_motor_cw && pos > 4'h0) pos <= pos - 4'h1;
    fence_open <= fence_sol_on;
    fence_closed <= !fence_sol_on;
  end
  assign lift_sensor = stack < 4'h8;
  assign rear_return = pos == 4'h8;
  assign rear_home_position = pos == 4'h0;
endmodule
`default_nettype wire

// File: bench/ttfs_sequencer_tb.sv
// Purpose: Directed bench for the feed sequencer
// Assumes: Debounce and timeouts shortened by parameters
// Notes: Lift and fence sensors come from the plant
`timescale 1ns/1ps
`default_nettype none
module ttfs_sequencer_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, feed = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, remaining_level;
  logic tray_set = 0, right_paper = 0, left_paper = 0, paper_end = 1, reg_sensor = 0;
  logic large_capacity_tray_exit_jam = 0, guide_position = 0, sheet_fed = 0, stall = 0;
  logic [3:0] height_sensor = 4'hf;
  logic [7:0] primary_level = 8'h10, secondary_level = 8'h10;
  logic [11:0] edge_position = 12'h805, laser_shift;
  logic lift_sensor, fence_open, fence_closed, rear_return, rear_home_position, paper_out;
  logic lift_motor_on, pickup_sol_on, fence_sol_on, rear_motor_ccw, rear_motor_cw, caution;
  logic left_lock_sol_on, guide_release_sol_on, guide_plate_sol_on, reg_motor_on, copy_block;
  logic relay_motor_on, feed_stop, load_left_msg, double_feed_err, motor_fault;
  int n_errors = 0, n_compared = 0, cyc = 0;
  assign hready = hreadyout;
  ttfs_sequencer #(.DEBOUNCE(4), .MOTOR_TIMEOUT(200), .RELEASE_PULSE(10)) i_ttfs_sequencer (.*);
  ttfs_plant i_ttfs_plant (.*);
  // Free-running 100 MHz clock
  initial forever #5 hclk = ~hclk;
  // Hang guard, far above the directed run
  always @(posedge hclk) if (cyc++ == 20000) wrap_up(1);
  task wrap_up(input int extra);
    n_errors += extra;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Single AHB transfer, read data lands in r
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hready);
    r = hrdata;
  endtask
  // Directed sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h0, 8'h40, 32'h0);
    chk("unmap", r, 32'h0);
    ahb(1'h1, 8'h0c, 32'h5);
    ahb(1'h1, 8'h10, 32'h3);
    ahb(1'h1, 8'h14, 32'h14);
    ahb(1'h1, 8'h00, 32'h3);
    tray_set <= 1'h1;
    left_paper <= 1'h1;
    wait (rear_motor_ccw) #1;
    chk("open", fence_open, 1'h1);
    chk("lock", left_lock_sol_on, 1'h1);
    wait (rear_motor_cw) #1;
    chk("fence", fence_sol_on, 1'h0);
    // Stack now in the right tray; else a second transfer starts
    @(posedge hclk);
    left_paper <= 1'h0;
    wait (load_left_msg) #1;
    chk("shut", fence_closed, 1'h1);
    wait (!rear_motor_cw) #1;
    @(posedge hclk);
    right_paper <= 1'h1;
    wait (lift_motor_on) #1;
    chk("pick", pickup_sol_on, 1'h1);
    wait (!lift_motor_on) #1;
    chk("lift", lift_sensor, 1'h0);
    ahb(1'h0, 8'h08, 32'h0);
    chk("tray", r[0], 1'h1);
    for (int k = 0; k < 5; k++) begin
      height_sensor <= 4'hf >> k;
      repeat (12) @(posedge hclk);
      chk("level", remaining_level, k);
    end
    paper_end <= 1'h0;
    guide_position <= 1'h1;
    repeat (12) @(posedge hclk);
    chk("out", paper_out, 1'h1);
    chk("block", copy_block, 1'h1);
    guide_position <= 1'h0;
    repeat (12) @(posedge hclk);
    reg_sensor <= 1'h1;
    wait (!relay_motor_on) #1;
    chk("reg", reg_motor_on, 1'h0);
    chk("shift", laser_shift, 32'(12'h805 - ttfs_pkg::EDGE_NOMINAL_RESET));
    wait (reg_motor_on) #1;
    chk("relay", relay_motor_on, 1'h1);
    @(posedge hclk);
    primary_level <= 8'h80;
    wait (double_feed_err) #1;
    chk("dbl", feed_stop, 1'h1);
    @(posedge hclk);
    reg_sensor <= 1'h0;
    primary_level <= 8'h10;
    ahb(1'h1, 8'h04, 32'h1);
    sheet_fed <= 1'h1;
    repeat (10) @(posedge hclk);
    sheet_fed <= 1'h0;
    wait (guide_plate_sol_on) #1;
    chk("jam", feed_stop, 1'h1);
    // Clear stop and message so the exit jam stop stands alone
    ahb(1'h1, 8'h04, 32'h3);
    @(posedge hclk);
    chk("msg", load_left_msg, 1'h0);
    chk("clear", feed_stop, 1'h0);
    large_capacity_tray_exit_jam <= 1'h1;
    wait (guide_release_sol_on) #1;
    chk("exit", feed_stop, 1'h1);
    @(posedge hclk);
    stall <= 1'h1;
    feed <= 1'h1;
    @(posedge hclk);
    feed <= 1'h0;
    wait (motor_fault) #1;
    chk("halt", lift_motor_on, 1'h0);
    wrap_up(0);
  end
endmodule
`default_nettype wire
